// ### cnco_top.sv
// Carrier frequency setting, shift, byte sequencer, oscillator and level select
`timescale 1ns/100ps
`include "cnco_map.svh"
// Summary of operation
// RULE_01 - Four decimal switches set 30.0-535.0 kHz
// RULE_02 - Decimal setting converted to 13-bit binary
// RULE_03 - Shift up adds, shift down subtracts offset
// RULE_04 - Offset switch picks 0-750 Hz, 50 Hz
// RULE_05 - Sequencer drives address, write, load, two bytes
// RULE_06 - Oscillator takes increment as two bytes
// RULE_07 - Accumulator adds 16-bit increment every clock
// RULE_08 - Output equals clock times increment over 65536
// RULE_09 - Top 13 accumulator bits address the sine
// RULE_10 - Each sine sample is 12 bits
// RULE_11 - Oscillator held reset while transmit key off
// RULE_12 - Select bits equal give low-level channel
// RULE_13 - High-level key sets upper select bit
// RULE_14 - Voice key sets lower select bit
// RULE_15 - Keep output below about 40% clock; code only raises above_limit and still loads the increment
// RULE_16 - One clock drives control and oscillator
// RULE_17 - Any setting change rewrites bytes, then loads; code rewrites only when the valid increment changes
module cnco_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Front panel setting
  input wire cnco_pkg::cnco_digits_t frequency_digit_switches,
  input wire logic [3:0] offset_select_switch,
  // Keying inputs
  input wire logic shift_up_key,
  input wire logic shift_down_key,
  input wire logic any_tx_key,
  input wire logic high_level_key,
  input wire logic voice_key,
  // Oscillator byte bus, observable
  output cnco_pkg::cnco_nco_bus_t nco_bus,
  // Converter and level select
  output logic [11:0] dac_sample,
  output cnco_pkg::cnco_mod_sel_t modulation_level_mux,
  // Status
  output logic nco_held,
  output logic setting_invalid,
  output logic above_limit,
  output logic seq_busy,
  output logic [15:0] phase_inc
);
  localparam int SYNC_W = 24;

  logic [SYNC_W-1:0] raw_w;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  cnco_pkg::cnco_digits_t digits_w;
  logic [3:0] ofs_w;
  logic up_w;
  logic down_w;
  logic run_w;
  logic high_w;
  logic voice_w;

  logic [12:0] bin_w;
  logic digit_bad_w;
  logic range_bad_w;
  logic [19:0] base_hz_w;
  logic [19:0] ofs_hz_w;
  logic [19:0] freq_hz_w;
  logic [39:0] scaled_w;
  logic [15:0] target_nxt;
  logic [15:0] target_r;
  logic [15:0] sent_r;
  logic [15:0] shadow_r;
  logic invalid_r;
  logic limit_r;

  cnco_pkg::cnco_seq_state_t state_r;
  cnco_pkg::cnco_seq_state_t state_nxt;
  cnco_pkg::cnco_nco_bus_t bus_r;
  cnco_pkg::cnco_nco_bus_t bus_nxt;
  cnco_pkg::cnco_mod_sel_t sel_r;

  // Panel switches and keys are asynchronous to the clock
  assign raw_w = {frequency_digit_switches, offset_select_switch,
                  shift_up_key, shift_down_key, any_tx_key, high_level_key, voice_key};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= raw_w[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign digits_w = sync_r[23:9]; // RULE_01
  assign ofs_w = sync_r[8:5];
  assign up_w = sync_r[4];
  assign down_w = sync_r[3];
  assign run_w = sync_r[2];
  assign high_w = sync_r[1];
  assign voice_w = sync_r[0];

  // A digit above nine is not a decimal digit
  function automatic logic digit_over(input logic [3:0] d);
    digit_over = (d > 4'h9);
  endfunction

  // Decimal to binary: hundreds*1000 + tens*100 + units*10 + tenths
  function automatic logic [12:0] bcd_to_bin(input cnco_pkg::cnco_digits_t d);
    logic [12:0] acc;
    acc = 13'(d.hundreds) * 13'd1000;
    acc = acc + 13'(d.tens) * 13'd100;
    acc = acc + 13'(d.units) * 13'd10;
    acc = acc + 13'(d.tenths);
    bcd_to_bin = acc;
  endfunction

  assign bin_w = bcd_to_bin(digits_w); // RULE_02
  assign digit_bad_w = digit_over(digits_w.tens) || digit_over(digits_w.units) ||
                       digit_over(digits_w.tenths);
  assign range_bad_w = (bin_w < `CNCO_SET_MIN) || (bin_w > `CNCO_SET_MAX); // RULE_01

  // Offset is a binary count of 50 Hz steps, fifteen steps reaching 750 Hz
  assign ofs_hz_w = 20'(ofs_w) * 20'(`CNCO_OFS_STEP_HZ); // RULE_04
  assign base_hz_w = 20'(bin_w) * 20'(`CNCO_FREQ_STEP_HZ);

  // Both shift keys together cancel; neither direction is preferred
  always_comb begin
    if (up_w && !down_w) begin
      freq_hz_w = base_hz_w + ofs_hz_w; // RULE_03
    end else if (down_w && !up_w) begin
      freq_hz_w = base_hz_w - ofs_hz_w; // RULE_03
    end else begin
      freq_hz_w = base_hz_w;
    end
  end

  // Increment = f * 2^16 / reference clock; the reference makes this exact
  assign scaled_w = ({20'h0_0000, freq_hz_w} * 40'(`CNCO_ACC_MOD)) /
                    40'(`CNCO_REF_CLK_HZ); // RULE_08
  assign target_nxt = scaled_w[15:0];

  // A bad setting keeps the last good increment rather than loading garbage
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      target_r <= 16'h0000;
      invalid_r <= 1'b0;
    end else begin
      invalid_r <= digit_bad_w || range_bad_w;
      if (!(digit_bad_w || range_bad_w)) begin
        target_r <= target_nxt;
      end
    end
  end

  // Advisory only: spurs above this are hard to filter, nothing is blocked
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      limit_r <= 1'b0;
    end else begin
      limit_r <= (32'(target_r) > `CNCO_INC_LIMIT); // RULE_15
    end
  end

  // Byte sequencer: low byte, high byte, then load
  always_comb begin
    state_nxt = state_r;
    bus_nxt = bus_r;
    bus_nxt.wr_n = 1'b1;
    bus_nxt.load = 1'b0;
    case (state_r)
      cnco_pkg::SEQ_IDLE: begin
        if (target_r != sent_r) begin
          state_nxt = cnco_pkg::SEQ_LO_SET; // RULE_17
        end
      end
      cnco_pkg::SEQ_LO_SET: begin
        bus_nxt.addr = `CNCO_ADDR_LO; // RULE_05
        bus_nxt.data = shadow_r[7:0];
        state_nxt = cnco_pkg::SEQ_LO_WR;
      end
      cnco_pkg::SEQ_LO_WR: begin
        bus_nxt.wr_n = 1'b0; // RULE_05
        state_nxt = cnco_pkg::SEQ_HI_SET;
      end
      cnco_pkg::SEQ_HI_SET: begin
        bus_nxt.addr = `CNCO_ADDR_HI; // RULE_05
        bus_nxt.data = shadow_r[15:8];
        state_nxt = cnco_pkg::SEQ_HI_WR;
      end
      cnco_pkg::SEQ_HI_WR: begin
        bus_nxt.wr_n = 1'b0;
        state_nxt = cnco_pkg::SEQ_LOAD;
      end
      cnco_pkg::SEQ_LOAD: begin
        bus_nxt.load = 1'b1; // RULE_17
        state_nxt = cnco_pkg::SEQ_IDLE;
      end
      default: begin
        state_nxt = cnco_pkg::SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= cnco_pkg::SEQ_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Bus outputs come straight from flip-flops so the strobes are glitch free
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_r <= '{addr: 1'b0, wr_n: 1'b1, load: 1'b0, data: 8'h00};
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // Snapshot keeps both bytes of one word consistent if the switches move
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      shadow_r <= 16'h0000;
      sent_r <= 16'h0000;
    end else if (state_r == cnco_pkg::SEQ_IDLE && target_r != sent_r) begin
      shadow_r <= target_r;
      sent_r <= target_r;
    end
  end

  // Level select: upper bit from high-level key, lower from voice key
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sel_r <= '{upper: 1'b0, lower: 1'b0};
    end else begin
      sel_r.upper <= high_w; // RULE_13 RULE_12
      sel_r.lower <= voice_w; // RULE_14 RULE_12
    end
  end

  // Single clock feeds both the control logic and the synthesizer
  cnco_phase_synth u_phase_synthesizer ( // RULE_16
    .sys_clk(sys_clk),
    .reset(reset),
    .nco_run(run_w), // RULE_11
    .nco_bus(bus_r),
    .dac_sample(dac_sample),
    .phase_inc(phase_inc)
  );

  assign nco_bus = bus_r;
  assign modulation_level_mux = sel_r;
  assign nco_held = !run_w;
  assign setting_invalid = invalid_r;
  assign above_limit = limit_r;
  assign seq_busy = (state_r != cnco_pkg::SEQ_IDLE);

  a_seq_order: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (reset)
    $rose(seq_busy) |-> ##1 (nco_bus.wr_n && nco_bus.addr == `CNCO_ADDR_LO)
      ##1 !nco_bus.wr_n ##1 (nco_bus.wr_n && nco_bus.addr == `CNCO_ADDR_HI)
      ##1 !nco_bus.wr_n ##1 (nco_bus.wr_n && nco_bus.load))
    else $error("byte sequence out of order");
  a_load_word: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (reset)
    nco_bus.load |=> phase_inc == $past(shadow_r))
    else $error("loaded increment differs from target");
  a_change_write: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (reset)
    (!seq_busy && target_r != sent_r) |-> ##[1:12] nco_bus.load)
    else $error("setting change not written");
  a_sel_high: assert property ( // RULE_13
    @(posedge sys_clk) disable iff (reset)
    high_w && !voice_w |=> modulation_level_mux == 2'b10)
    else $error("high-level key did not pick channel 2");
  a_sel_voice: assert property ( // RULE_14
    @(posedge sys_clk) disable iff (reset)
    voice_w && !high_w |=> modulation_level_mux == 2'b01)
    else $error("voice key did not pick channel 1");
  a_sel_low: assert property ( // RULE_12
    @(posedge sys_clk) disable iff (reset)
    (high_w == voice_w) |=> modulation_level_mux.upper == modulation_level_mux.lower)
    else $error("low-level select bits differ");
  a_bad_hold: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (reset)
    (digit_bad_w || range_bad_w) |=> target_r == $past(target_r) && setting_invalid)
    else $error("invalid setting altered the target");
  a_shift_dir: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (reset)
    (up_w && !down_w) |-> freq_hz_w == base_hz_w + ofs_hz_w)
    else $error("upward shift not added");
  a_limit_flag: assert property ( // RULE_15
    @(posedge sys_clk) disable iff (reset)
    (32'(target_r) > `CNCO_INC_LIMIT) |=> above_limit)
    else $error("limit flag missing");

  // Strobe shape, bus hold around each byte write and sequence length
  a_load_pulse: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (reset)
    nco_bus.load |=> !nco_bus.load)
    else $error("load strobe longer than one cycle");
  a_write_pulse: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (reset)
    !nco_bus.wr_n |=> nco_bus.wr_n)
    else $error("write strobe longer than one cycle");
  a_write_hold: assert property ( // RULE_06
    @(posedge sys_clk) disable iff (reset)
    !nco_bus.wr_n |-> $stable(nco_bus.addr) && $stable(nco_bus.data))
    else $error("byte changed under the write strobe");
  a_busy_span: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (reset)
    $rose(seq_busy) |-> ##5 !seq_busy)
    else $error("sequencer did not finish in five cycles");

  // Setting checks, conversion and level select
  a_range_flag: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (reset)
    range_bad_w |=> setting_invalid)
    else $error("out-of-range setting not flagged");
  a_digit_flag: assert property ( // RULE_02
    @(posedge sys_clk) disable iff (reset)
    digit_bad_w |=> setting_invalid)
    else $error("non-decimal digit not flagged");
  a_target_step: assert property ( // RULE_02
    @(posedge sys_clk) disable iff (reset)
    !(digit_bad_w || range_bad_w) |=> target_r == $past(target_nxt))
    else $error("valid setting not taken as target");
  a_shift_down: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (reset)
    (down_w && !up_w) |-> freq_hz_w == base_hz_w - ofs_hz_w)
    else $error("downward shift not subtracted");
  a_ofs_span: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (reset)
    ofs_hz_w <= 20'(`CNCO_OFS_MAX_HZ))
    else $error("offset beyond its span");
  a_sel_both: assert property ( // RULE_12
    @(posedge sys_clk) disable iff (reset)
    (high_w && voice_w) |=> modulation_level_mux == 2'b11)
    else $error("both keys did not pick channel 3");
endmodule

// ### cnco_map.svh
// Constants for the carrier oscillator frequency control block
`ifndef CNCO_MAP_SVH
`define CNCO_MAP_SVH
`define CNCO_BCD_W 15
`define CNCO_BIN_W 13
`define CNCO_OFS_W 4
`define CNCO_ACC_W 16
`define CNCO_LUT_AW 13
`define CNCO_DAC_W 12
`define CNCO_SET_MIN 13'd300
`define CNCO_SET_MAX 13'd5350
`define CNCO_FREQ_STEP_HZ 100
`define CNCO_OFS_STEP_HZ 50
`define CNCO_OFS_MAX_HZ 750
`define CNCO_REF_CLK_HZ 3276800
`define CNCO_ACC_MOD 65536
`define CNCO_LIMIT_PCT 40
`define CNCO_INC_LIMIT ((`CNCO_ACC_MOD * `CNCO_LIMIT_PCT) / 100)
`define CNCO_ADDR_LO 1'b0
`define CNCO_ADDR_HI 1'b1
`define CNCO_DAC_MID 12'h0800
`define CNCO_DAC_PEAK 12'h07FF
`endif

// ### cnco_pkg.sv
// Types shared by the carrier oscillator frequency control files
package cnco_pkg;
  typedef struct packed {
    logic [2:0] hundreds;
    logic [3:0] tens;
    logic [3:0] units;
    logic [3:0] tenths;
  } cnco_digits_t;
  typedef struct packed {
    logic addr;
    logic wr_n;
    logic load;
    logic [7:0] data;
  } cnco_nco_bus_t;
  typedef struct packed {
    logic upper;
    logic lower;
  } cnco_mod_sel_t;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_LO_SET, SEQ_LO_WR, SEQ_HI_SET, SEQ_HI_WR, SEQ_LOAD
  } cnco_seq_state_t;
endpackage

// ### cnco_phase_synth.sv
// Phase synthesizer: increment holding registers, accumulator, sine shaping
`timescale 1ns/100ps
`include "cnco_map.svh"
module cnco_phase_synth (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Run enable from the transmitter key
  input wire logic nco_run,
  // Byte bus from the sequencer
  input wire cnco_pkg::cnco_nco_bus_t nco_bus,
  // Sample to the converter and the loaded increment
  output logic [11:0] dac_sample,
  output logic [15:0] phase_inc
);
  logic [7:0] inc_lo_r;
  logic [7:0] inc_hi_r;
  logic [15:0] inc_r;
  logic [15:0] acc_r;
  logic [11:0] sample_r;
  logic [11:0] x_w;
  logic [23:0] prod_w;
  logic [11:0] mag_w;

  // Bytes land while the write strobe is low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inc_lo_r <= 8'h00;
      inc_hi_r <= 8'h00;
    end else if (!nco_bus.wr_n) begin
      if (nco_bus.addr == `CNCO_ADDR_LO) begin
        inc_lo_r <= nco_bus.data; // RULE_06
      end else begin
        inc_hi_r <= nco_bus.data; // RULE_06
      end
    end
  end

  // Increment changes only on the load strobe, so a half-written word never runs
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inc_r <= 16'h0000;
    end else if (nco_bus.load) begin
      inc_r <= {inc_hi_r, inc_lo_r}; // RULE_17
    end
  end

  // Held cleared while the key is off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      acc_r <= 16'h0000;
    end else if (!nco_run) begin
      acc_r <= 16'h0000; // RULE_11
    end else begin
      acc_r <= acc_r + inc_r; // RULE_07 RULE_08
    end
  end

  // Parabolic half-wave approximates the sine without a large table
  // Top 13 bits: bit 15 picks the half wave, bits 14:3 the place within it
  assign x_w = acc_r[14:3]; // RULE_09
  assign prod_w = {12'h000, x_w} * {12'h000, 12'hFFF - x_w};
  assign mag_w = (prod_w[23:11] > {1'b0, `CNCO_DAC_PEAK}) ? `CNCO_DAC_PEAK : prod_w[22:11];

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sample_r <= `CNCO_DAC_MID;
    end else if (!nco_run) begin
      sample_r <= `CNCO_DAC_MID;
    end else if (acc_r[15]) begin
      sample_r <= `CNCO_DAC_MID - mag_w; // RULE_10
    end else begin
      sample_r <= `CNCO_DAC_MID + mag_w; // RULE_10
    end
  end

  assign dac_sample = sample_r;
  assign phase_inc = inc_r;

  a_acc_step: assert property ( // RULE_07
    @(posedge sys_clk) disable iff (reset)
    $past(nco_run) |-> acc_r == 16'($past(acc_r) + $past(inc_r)))
    else $error("accumulator did not advance by the increment");
  a_load_word: assert property ( // RULE_17
    @(posedge sys_clk) disable iff (reset)
    nco_bus.load |=> inc_r == $past({inc_hi_r, inc_lo_r}))
    else $error("increment not adopted on load");
  a_hold_reset: assert property ( // RULE_11
    @(posedge sys_clk) disable iff (reset)
    !nco_run |=> acc_r == 16'h0000 && sample_r == `CNCO_DAC_MID)
    else $error("synthesizer not held while key is off");
  a_sine_half: assert property ( // RULE_10
    @(posedge sys_clk) disable iff (reset)
    nco_run && !acc_r[15] |=> sample_r >= `CNCO_DAC_MID)
    else $error("first half of the wave below midscale");
endmodule

// ### cnco_keying_model.sv
// Keying module stand-in that drives the transmitter key levels
`timescale 1ns/100ps
module cnco_keying_model (
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic tx_req,
  input wire logic hi_req,
  input wire logic voice_req,
  // Key levels to the transmitter
  output logic any_tx_key,
  output logic high_level_key,
  output logic voice_key
);
  initial begin
    any_tx_key = 1'b0;
    high_level_key = 1'b0;
    voice_key = 1'b0;
  end

  // Keys move only between rising edges so the synchroniser never sees a race
  always @(negedge sys_clk) begin
    any_tx_key <= tx_req;
    high_level_key <= hi_req;
    voice_key <= voice_req;
  end
endmodule

// ### test_carrier_nco_frequency_control.sv
// Self-checking bench for the carrier oscillator frequency control block
`timescale 1ns/100ps
`include "cnco_map.svh"
module test_carrier_nco_frequency_control;
  logic sys_clk;
  logic reset;
  cnco_pkg::cnco_digits_t digits;
  logic [3:0] ofs;
  logic up_key;
  logic down_key;
  logic tx_req;
  logic hi_req;
  logic voice_req;
  logic any_tx_key;
  logic high_level_key;
  logic voice_key;
  cnco_pkg::cnco_nco_bus_t nco_bus;
  logic [11:0] dac_sample;
  cnco_pkg::cnco_mod_sel_t mux;
  logic nco_held;
  logic setting_invalid;
  logic above_limit;
  logic seq_busy;
  logic [15:0] phase_inc;
  logic [11:0] samp [32];
  logic varied;
  int n_fail;
  int checks_done;
  int i;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  cnco_keying_model keys (.sys_clk(sys_clk), .tx_req(tx_req), .hi_req(hi_req),
    .voice_req(voice_req), .any_tx_key(any_tx_key), .high_level_key(high_level_key),
    .voice_key(voice_key));

  cnco_top DUT (.sys_clk(sys_clk), .reset(reset), .frequency_digit_switches(digits),
    .offset_select_switch(ofs), .shift_up_key(up_key), .shift_down_key(down_key),
    .any_tx_key(any_tx_key), .high_level_key(high_level_key), .voice_key(voice_key),
    .nco_bus(nco_bus), .dac_sample(dac_sample), .modulation_level_mux(mux),
    .nco_held(nco_held), .setting_invalid(setting_invalid), .above_limit(above_limit),
    .seq_busy(seq_busy), .phase_inc(phase_inc));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Sets the panel and follows the two byte writes up to the load pulse
  task automatic load_setting(input logic [2:0] h, input logic [3:0] t, input logic [3:0] u,
      input logic [3:0] d, input logic [3:0] o, input logic up, input logic dn,
      input logic [15:0] exp);
    logic [15:0] got;
    int nb;
    int j;
    got = 16'h0000;
    nb = 0;
    @(negedge sys_clk);
    digits = '{h, t, u, d};
    ofs = o;
    up_key = up;
    down_key = dn;
    for (j = 0; j < 40 && nco_bus.load !== 1'b1; j++) begin
      @(negedge sys_clk);
      if (nco_bus.wr_n === 1'b0) begin
        check({14'h0000, nco_bus.addr, seq_busy}, {15'(nb), 1'b1}, "byte order");
        if (nb == 0) got[7:0] = nco_bus.data;
        else got[15:8] = nco_bus.data;
        nb++;
      end
    end
    check(16'(nb), 16'h0002, "bytes before load");
    check(got, exp, "increment bytes");
    @(negedge sys_clk);
    check(phase_inc, exp, "increment adopted");
    check({15'h0000, setting_invalid}, 16'h0000, "setting accepted");
  endtask

  // Rejected setting (out of range or non-decimal digit): no load pulse may occur and the old increment stays
  task automatic refuse(input logic [2:0] h, input logic [3:0] t, input logic [3:0] u,
      input logic [3:0] d, input logic [15:0] keep);
    int j;
    @(negedge sys_clk);
    digits = '{h, t, u, d};
    for (j = 0; j < 20; j++) begin
      @(negedge sys_clk);
      check({15'h0000, nco_bus.load}, 16'h0000, "no load on bad setting");
    end
    check({15'h0000, setting_invalid}, 16'h0001, "invalid flag");
    check(phase_inc, keep, "increment kept");
  endtask

  task automatic grab();
    for (int j = 0; j < 32; j++) begin
      @(negedge sys_clk);
      samp[j] = dac_sample;
    end
  endtask

  initial begin
    #250000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    digits = '0;
    ofs = 4'h0;
    up_key = 1'b0;
    down_key = 1'b0;
    tx_req = 1'b0;
    hi_req = 1'b0;
    voice_req = 1'b0;
    reset = 1'b1;
    n_fail = 0;
    checks_done = 0;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    check(16'(nco_bus), 16'h0200, "bus idle after reset");
    check({4'h0, dac_sample}, {4'h0, `CNCO_DAC_MID}, "midscale after reset");
    check({15'h0000, nco_held}, 16'h0001, "held after reset");
    check(phase_inc, 16'h0000, "increment after reset");
    load_setting(3'h1, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h07D0);
    load_setting(3'h1, 4'h0, 4'h0, 4'h0, 4'hF, 1'b1, 1'b0, 16'h07DF);
    load_setting(3'h1, 4'h0, 4'h0, 4'h0, 4'h5, 1'b0, 1'b1, 16'h07CB);
    load_setting(3'h1, 4'h0, 4'h0, 4'h0, 4'h5, 1'b1, 1'b1, 16'h07D0);
    for (i = 0; i < 4; i++)
      load_setting(3'h1, 4'h0, 4'h0, 4'h0, 4'(1 << i), 1'b1, 1'b0,
          16'h07D0 + 16'(1 << i));
    load_setting(3'h0, 4'h3, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 16'h0258);
    load_setting(3'h5, 4'h3, 4'h5, 4'h0, 4'h0, 1'b0, 1'b0, 16'h29CC);
    check({15'h0000, above_limit}, 16'h0000, "top of band under limit");
    refuse(3'h5, 4'h3, 4'h5, 4'h1, 16'h29CC);
    refuse(3'h1, 4'h0, 4'h0, 4'hA, 16'h29CC);
    load_setting(3'h4, 4'h0, 4'h9, 4'h6, 4'h0, 1'b0, 1'b0, 16'h2000);
    tx_req = 1'b1;
    for (i = 0; i < 10 && nco_held !== 1'b0; i++) @(negedge sys_clk);
    check({15'h0000, nco_held}, 16'h0000, "released by key");
    repeat (4) @(negedge sys_clk);
    grab();
    varied = 1'b0;
    for (i = 0; i < 24; i++) begin
      check({4'h0, samp[i]}, {4'h0, samp[i + 8]}, "eight cycle period");
      if (samp[i] !== samp[0]) varied = 1'b1;
    end
    check({15'h0000, varied}, 16'h0001, "sine moves");
    load_setting(3'h2, 4'h0, 4'h4, 4'h8, 4'h0, 1'b0, 1'b0, 16'h1000);
    grab();
    varied = 1'b0;
    for (i = 0; i < 16; i++) begin
      check({4'h0, samp[i]}, {4'h0, samp[i + 16]}, "sixteen cycle period");
      if (samp[i] !== samp[i + 8]) varied = 1'b1;
    end
    check({15'h0000, varied}, 16'h0001, "half periods differ");
    tx_req = 1'b0;
    for (i = 0; i < 10 && nco_held !== 1'b1; i++) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
    check({3'h0, nco_held, dac_sample}, {3'h0, 1'b1, `CNCO_DAC_MID}, "held midscale");
    check(phase_inc, 16'h1000, "increment survives key off");
    for (i = 0; i < 4; i++) begin
      hi_req = i[1];
      voice_req = i[0];
      repeat (5) @(negedge sys_clk);
      check({14'h0000, mux}, 16'(i), "level select");
    end
    summarize();
  end
endmodule
